/* src/ftssp_pkg.sv */
// Shared constants, types and decoding for the flow-through SRAM port.
package ftssp_pkg;

    // ********
    // Widths and sizes
    // ********
    localparam int DATA_W     = 48;
    localparam int ADDR_W     = 21;
    localparam int LANES      = 6;
    localparam int LANE_W     = 8;
    localparam int BURST_W    = 2;
    localparam int FIFO_DEPTH = 16;

    // ********
    // Field positions of a queued write entry
    // ********
    localparam int ENT_DATA_LSB = 0;
    localparam int ENT_LANE_LSB = DATA_W;
    localparam int ENT_ADDR_LSB = DATA_W + LANES;
    localparam int ENT_W        = DATA_W + LANES + ADDR_W;

    // ********
    // Timing counts and reset values
    // ********
    localparam int               INIT_CYCLES = 16;
    localparam int               INIT_W      = 5;
    localparam logic [47:0]      DQ_RST      = 48'h0000_0000_0000;
    localparam logic [1:0]       BURST_RST   = 2'h0;
    localparam logic [INIT_W-1:0] INIT_RST   = 5'h00;

    typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_SLEEP, ST_SHUT} ftssp_state_type;

    // Expands active-low byte lanes into a bit mask of bytes to write.
    function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] lanesN);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{~lanesN[i]}};
        end
        return m;
    endfunction : lane_mask

endpackage : ftssp_pkg

/* src/ftssp_fifo_if.sv */
// Interface carrying both sides of the write queue.
`timescale 1ns/1ps
interface ftssp_fifo_if #(
    parameter int W  = 8,
    parameter int CW = 5
);
    logic          inValid;
    logic          inReady;
    logic [W-1:0]  inData;
    logic          outValid;
    logic          outReady;
    logic [W-1:0]  outData;
    logic [CW-1:0] count;

    modport fifo (input inValid, inData, outReady, output inReady, outValid, outData, count);
    modport user (output inValid, inData, outReady, input inReady, outValid, outData, count);
endinterface : ftssp_fifo_if

/* src/ftssp_fifo.sv */
// Parameterised write queue with valid and ready on both sides.
`timescale 1ns/1ps
module ftssp_fifo
    import ftssp_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic  clk,
    input  wire logic  rst_b,
    input  wire logic  clkEn,
    input  wire logic  flush,
    ftssp_fifo_if.fifo q
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] wrPtr_nxt;
    logic [PW-1:0] rdPtr_r;
    logic [PW-1:0] rdPtr_nxt;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          push;
    logic          pop;

    assign q.inReady  = (count_r != CW'(DEPTH));
    assign q.outValid = (count_r != '0);
    assign q.outData  = mem[rdPtr_r];
    assign q.count    = count_r;
    assign push       = q.inValid & q.inReady & ~flush;
    assign pop        = q.outValid & q.outReady & ~flush;

    // ********
    // Pointer and count update
    // ********
    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (flush) begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            count_nxt = '0;
        end else begin
            if (push) begin
                wrPtr_nxt = (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_nxt = (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_nxt = count_r + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (clkEn) begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (clkEn && push) begin
            mem[wrPtr_r] <= q.inData;
        end
    end

endmodule : ftssp_fifo

/* src/ftssp_burst.sv */
// Two-bit burst address counter, linear or interleaved.
`timescale 1ns/1ps
module ftssp_burst
    import ftssp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               clkEn,
    input  wire logic               load,
    input  wire logic               advance,
    input  wire logic               interleave,
    input  wire logic [BURST_W-1:0] start,
    output logic      [BURST_W-1:0] accLow
);
    logic [BURST_W-1:0] start_r;
    logic [BURST_W-1:0] start_nxt;
    logic [BURST_W-1:0] step_r;
    logic [BURST_W-1:0] step_nxt;
    logic [BURST_W-1:0] stepUp;

    assign stepUp = step_r + 1'b1;

    // ********
    // Next access low bits
    // ********
    always_comb begin
        start_nxt = start_r;
        step_nxt  = step_r;
        accLow    = start;
        if (load) begin
            start_nxt = start;
            step_nxt  = BURST_RST;
        end else if (advance) begin
            step_nxt = stepUp;
            accLow   = interleave ? (start_r ^ stepUp) : (start_r + stepUp);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_r <= BURST_RST;
            step_r  <= BURST_RST;
        end else if (clkEn) begin
            start_r <= start_nxt;
            step_r  <= step_nxt;
        end
    end

endmodule : ftssp_burst

/* src/ftssp_top.sv */
// Synchronous control and data port of a flow-through synchronous SRAM.
`timescale 1ns/1ps
module ftssp_top
    import ftssp_pkg::*;
#(
    parameter int AW         = ADDR_W,
    parameter int DEPTH      = FIFO_DEPTH,
    parameter int INIT_COUNT = INIT_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clkEn,
    input  wire logic              clockQualifyN,
    input  wire logic              addrAdvanceOrLoad,
    input  wire logic              selectAN,
    input  wire logic              selectB,
    input  wire logic              selectCN,
    input  wire logic              writeN,
    input  wire logic [LANES-1:0]  byteWriteLaneN,
    input  wire logic [AW-1:0]     addr,
    input  wire logic              outputEnN,
    input  wire logic [DATA_W-1:0] dqIn,
    output logic      [DATA_W-1:0] dqOut,
    output logic                   dqOeN,
    input  wire logic              sleepRequest,
    input  wire logic              shutdown,
    input  wire logic              burstMode,
    output logic                   readyOut,
    output logic                   readyOeN
);
    localparam int EW = AW + LANES + DATA_W;
    localparam int CW = $clog2(DEPTH + 1);

    // ********
    // Declarations
    // ********
    ftssp_state_type     state_r;
    ftssp_state_type     state_nxt;
    logic [INIT_W-1:0]   initCnt_r;
    logic [INIT_W-1:0]   initCnt_nxt;
    logic                interleave_r;
    logic                interleave_nxt;
    logic                oeSync1_r;
    logic                oeSync_r;
    logic                shutSync1_r;
    logic                shutSync_r;
    logic                modeSync1_r;
    logic                modeSync_r;
    logic                active_r;
    logic                active_nxt;
    logic                isWrite_r;
    logic                isWrite_nxt;
    logic [AW-1:BURST_W] base_r;
    logic [AW-1:BURST_W] base_nxt;
    logic                wrPend_r;
    logic                wrPend_nxt;
    logic [AW-1:0]       wrAddr_r;
    logic [AW-1:0]       wrAddr_nxt;
    logic [LANES-1:0]    wrLanes_r;
    logic [LANES-1:0]    wrLanes_nxt;
    logic                rdValid_r;
    logic                rdValid_nxt;
    logic [DATA_W-1:0]   dqOut_r;
    logic [DATA_W-1:0]   dqOut_nxt;
    logic                readyOk_r;
    logic                readyOk_nxt;
    logic                readyPulse_r;
    logic                readyPulse_nxt;
    logic [DATA_W-1:0]   mem [2**AW];
    logic                qual;
    logic                run;
    logic                sel;
    logic                loadCyc;
    logic                advCyc;
    logic                startAcc;
    logic                accWrite;
    logic [BURST_W-1:0]  accLow;
    logic [AW-1:0]       accAddr;
    logic                drain;
    logic [AW-1:0]       headAddr;
    logic [DATA_W-1:0]   headMask;
    logic [DATA_W-1:0]   headData;
    logic [DATA_W-1:0]   rdWord;

    ftssp_fifo_if #(.W(EW), .CW(CW)) wq ();

    // ********
    // Input synchronisers for asynchronous pins
    // ********
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oeSync1_r   <= 1'b1;
            oeSync_r    <= 1'b1;
            shutSync1_r <= 1'b0;
            shutSync_r  <= 1'b0;
            modeSync1_r <= 1'b0;
            modeSync_r  <= 1'b0;
        end else if (clkEn) begin
            oeSync1_r   <= outputEnN;
            oeSync_r    <= oeSync1_r;
            shutSync1_r <= shutdown;
            shutSync_r  <= shutSync1_r;
            modeSync1_r <= burstMode;
            modeSync_r  <= modeSync1_r;
        end
    end

    // ********
    // Access decode
    // ********
    assign qual     = clkEn & ~clockQualifyN;
    assign run      = (state_r == ST_RUN);
    assign sel      = ~selectAN & selectB & ~selectCN;
    assign loadCyc  = run & qual & ~addrAdvanceOrLoad & sel;
    assign advCyc   = run & qual & addrAdvanceOrLoad & active_r;
    assign startAcc = loadCyc | advCyc;
    assign accWrite = loadCyc ? ~writeN : isWrite_r;
    assign accAddr  = {(loadCyc ? addr[AW-1:BURST_W] : base_r), accLow};

    ftssp_burst u_burst (
        .clk        (clk),
        .rst_b      (rst_b),
        .clkEn      (clkEn),
        .load       (loadCyc),
        .advance    (advCyc),
        .interleave (interleave_r),
        .start      (addr[BURST_W-1:0]),
        .accLow     (accLow)
    );

    // ********
    // Mode control
    // ********
    always_comb begin
        state_nxt      = state_r;
        initCnt_nxt    = initCnt_r;
        interleave_nxt = interleave_r;
        if (shutSync_r) begin
            state_nxt = ST_SHUT;
        end else begin
            unique case (state_r)
                ST_INIT: begin
                    initCnt_nxt = initCnt_r + 1'b1;
                    if (initCnt_r == INIT_W'(INIT_COUNT - 1)) begin
                        interleave_nxt = modeSync_r;
                        state_nxt      = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (qual && sleepRequest) begin
                        state_nxt = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (qual && !sleepRequest) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_SHUT: begin
                    state_nxt = ST_SHUT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r      <= ST_INIT;
            initCnt_r    <= INIT_RST;
            interleave_r <= 1'b0;
        end else if (clkEn) begin
            state_r      <= state_nxt;
            initCnt_r    <= initCnt_nxt;
            interleave_r <= interleave_nxt;
        end
    end

    // ********
    // Write queue and memory array
    // ********
    assign wq.inValid  = wrPend_r & qual;
    assign wq.inData   = {wrAddr_r, wrLanes_r, dqIn};
    assign wq.outReady = clkEn & (state_r != ST_SLEEP);
    assign drain       = wq.outValid & wq.outReady & (state_r != ST_SHUT);
    assign headAddr    = wq.outData[ENT_ADDR_LSB +: AW];
    assign headMask    = lane_mask(wq.outData[ENT_LANE_LSB +: LANES]);
    assign headData    = wq.outData[ENT_DATA_LSB +: DATA_W];

    ftssp_fifo #(.W(EW), .DEPTH(DEPTH), .CW(CW)) u_fifo (
        .clk   (clk),
        .rst_b (rst_b),
        .clkEn (clkEn),
        .flush (state_r == ST_SHUT),
        .q     (wq)
    );

    always_ff @(posedge clk) begin
        if (drain) begin
            mem[headAddr] <= (mem[headAddr] & ~headMask) | (headData & headMask);
        end
    end

    always_comb begin
        rdWord = mem[accAddr];
        if (drain && headAddr == accAddr) begin
            rdWord = (rdWord & ~headMask) | (headData & headMask);
        end
    end

    // ********
    // Access pipeline
    // ********
    always_comb begin
        active_nxt  = active_r;
        isWrite_nxt = isWrite_r;
        base_nxt    = base_r;
        wrPend_nxt  = wrPend_r;
        wrAddr_nxt  = wrAddr_r;
        wrLanes_nxt = wrLanes_r;
        rdValid_nxt = rdValid_r;
        dqOut_nxt   = dqOut_r;
        if (!run) begin
            active_nxt  = 1'b0;
            wrPend_nxt  = 1'b0;
            rdValid_nxt = 1'b0;
        end else if (qual) begin
            active_nxt  = startAcc;
            wrPend_nxt  = startAcc & accWrite;
            rdValid_nxt = startAcc & ~accWrite;
            wrAddr_nxt  = accAddr;
            wrLanes_nxt = byteWriteLaneN;
            if (loadCyc) begin
                isWrite_nxt = ~writeN;
                base_nxt    = addr[AW-1:BURST_W];
            end
            if (startAcc && !accWrite) begin
                dqOut_nxt = (state_r == ST_SHUT) ? DQ_RST : rdWord;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_r  <= 1'b0;
            isWrite_r <= 1'b0;
            base_r    <= '0;
            wrPend_r  <= 1'b0;
            wrAddr_r  <= '0;
            wrLanes_r <= '1;
            rdValid_r <= 1'b0;
            dqOut_r   <= DQ_RST;
        end else if (clkEn) begin
            active_r  <= active_nxt;
            isWrite_r <= isWrite_nxt;
            base_r    <= base_nxt;
            wrPend_r  <= wrPend_nxt;
            wrAddr_r  <= wrAddr_nxt;
            wrLanes_r <= wrLanes_nxt;
            rdValid_r <= rdValid_nxt;
            dqOut_r   <= dqOut_nxt;
        end
    end

    assign dqOut = dqOut_r;
    assign dqOeN = ~(rdValid_r & ~wrPend_r & ~oeSync_r);

    // ********
    // Ready output
    // ********
    always_comb begin
        readyOk_nxt    = run & wq.inReady & (wq.count <= CW'(1));
        readyPulse_nxt = readyOk_nxt & ~readyOk_r;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readyOk_r    <= 1'b0;
            readyPulse_r <= 1'b0;
        end else if (clkEn) begin
            readyOk_r    <= readyOk_nxt;
            readyPulse_r <= readyPulse_nxt;
        end
    end

    assign readyOut = readyOk_r;
    assign readyOeN = readyOk_r & ~readyPulse_r;

endmodule : ftssp_top

/* verification/ftssp_checker.sv */
// Concurrent checks on the pins of the flow-through SRAM port.
`timescale 1ns/1ps
module ftssp_checker
    import ftssp_pkg::*;
#(
    parameter int AW         = ADDR_W,
    parameter int DEPTH      = FIFO_DEPTH,
    parameter int INIT_COUNT = INIT_CYCLES
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              clkEn,
    input wire logic              clockQualifyN,
    input wire logic              addrAdvanceOrLoad,
    input wire logic              selectAN,
    input wire logic              selectB,
    input wire logic              selectCN,
    input wire logic              writeN,
    input wire logic [LANES-1:0]  byteWriteLaneN,
    input wire logic [AW-1:0]     addr,
    input wire logic              outputEnN,
    input wire logic [DATA_W-1:0] dqIn,
    input wire logic [DATA_W-1:0] dqOut,
    input wire logic              dqOeN,
    input wire logic              sleepRequest,
    input wire logic              shutdown,
    input wire logic              burstMode,
    input wire logic              readyOut,
    input wire logic              readyOeN
);
    // ********
    // Properties
    // ********
    logic qual;
    logic selOk;
    assign qual  = clkEn && !clockQualifyN;
    assign selOk = !selectAN && selectB && !selectCN;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    init_low_a: assert property ($rose(rst_b) |-> !readyOut [*3])
        else $error("ready high during init");
    ready_pulse_a: assert property ($rose(readyOut) |-> !readyOeN ##1 (readyOeN || !readyOut))
        else $error("ready pulse not one cycle");
    ready_low_a: assert property (!readyOut |-> !readyOeN)
        else $error("ready low not driven");
    desel_float_a: assert property (qual && !addrAdvanceOrLoad && !selOk |=> dqOeN)
        else $error("data driven when deselected");
    oe_float_a: assert property (outputEnN [*3] |-> dqOeN)
        else $error("data driven with output enable high");
    write_float_a: assert property (qual && !addrAdvanceOrLoad && selOk && !writeN |=> dqOeN)
        else $error("data driven in write data phase");
    read_drive_a: assert property ((!outputEnN && !sleepRequest && !shutdown) [*5] ##0
        (qual && readyOut && !addrAdvanceOrLoad && selOk && writeN) |=> !dqOeN)
        else $error("read data not driven");
    stretch_hold_a: assert property (clkEn && clockQualifyN |=> $stable(dqOut))
        else $error("read data changed on unqualified edge");
    shut_ready_a: assert property ($rose(shutdown) |-> ##[1:8] !readyOut)
        else $error("ready stayed high in shutdown");
endmodule : ftssp_checker

bind ftssp_top ftssp_checker #(.AW(AW), .DEPTH(DEPTH), .INIT_COUNT(INIT_COUNT)) u_ftssp_checker (
    .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .clockQualifyN(clockQualifyN),
    .addrAdvanceOrLoad(addrAdvanceOrLoad), .selectAN(selectAN), .selectB(selectB),
    .selectCN(selectCN), .writeN(writeN), .byteWriteLaneN(byteWriteLaneN), .addr(addr),
    .outputEnN(outputEnN), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
    .sleepRequest(sleepRequest), .shutdown(shutdown), .burstMode(burstMode),
    .readyOut(readyOut), .readyOeN(readyOeN)
);

/* verification/ftssp_ctl.sv */
// Behavioural memory controller driving the data side of the port.
`timescale 1ns/1ps
module ftssp_ctl
    import ftssp_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] dqOut,
    input  wire logic              dqOeN,
    input  wire logic              readyOut,
    input  wire logic              readyOeN,
    output logic                   clockQualifyN,
    output logic                   addrAdvanceOrLoad,
    output logic                   selectAN,
    output logic                   selectB,
    output logic                   selectCN,
    output logic                   writeN,
    output logic      [LANES-1:0]  byteWriteLaneN,
    output logic      [AW-1:0]     addr,
    output logic      [DATA_W-1:0] dqIn
);
    // ********
    // Data wire and ready pin
    // ********
    logic              drvOn = 1'h0;
    logic              readyPin;
    logic [DATA_W-1:0] wdat  = 48'h0000_0000_0000;
    logic [DATA_W-1:0] junk  = 48'h5555_5555_5555;
    initial begin
        clockQualifyN     = 1'h0;
        addrAdvanceOrLoad = 1'h0;
        {selectAN, selectB, selectCN} = 3'h4;
        writeN            = 1'h1;
        byteWriteLaneN    = 6'h3f;
        addr              = '0;
    end
    // A released wire toggles so that no stale value is read back.
    always @(posedge clk) begin
        junk <= ~junk;
    end
    assign dqIn     = !dqOeN ? dqOut : (drvOn ? wdat : junk);
    assign readyPin = readyOeN ? 1'h1 : readyOut;
    // ********
    // Bus cycles
    // ********
    task automatic cyc(input logic adv, input logic [2:0] sel, input logic wr,
                       input logic [LANES-1:0] ln, input logic [AW-1:0] a,
                       input logic q, input logic dv);
        @(posedge clk);
        clockQualifyN     <= q;
        addrAdvanceOrLoad <= adv;
        {selectAN, selectB, selectCN} <= sel;
        writeN            <= wr;
        byteWriteLaneN    <= ln;
        addr              <= a;
        drvOn             <= dv;
    endtask : cyc
    task automatic idle();
        cyc(1'h0, 3'h4, 1'h1, 6'h3f, '0, 1'h0, 1'h0);
    endtask : idle
    task automatic rd(input logic [2:0] sel, input logic [AW-1:0] a);
        cyc(1'h0, sel, 1'h1, 6'h3f, a, 1'h0, 1'h0);
        idle();
    endtask : rd
    task automatic wr(input logic [AW-1:0] a, input logic [LANES-1:0] ln,
                      input logic [DATA_W-1:0] d);
        cyc(1'h0, 3'h2, 1'h0, ln, a, 1'h0, 1'h0);
        wdat <= d;
        cyc(1'h0, 3'h4, 1'h1, 6'h3f, '0, 1'h0, 1'h1);
        idle();
    endtask : wr
    task automatic waitReady();
        for (int i = 0; i < 100; i++) begin
            idle();
            #1;
            if (readyPin === 1'h1) begin
                break;
            end
        end
    endtask : waitReady
endmodule : ftssp_ctl

/* verification/tb_top.sv */
// Self-checking bench of the flow-through SRAM port.
`timescale 1ns/1ps
module tb_top
    import ftssp_pkg::*;
;
    // ********
    // Signals and instances
    // ********
    localparam int                TAW  = 8;
    localparam logic [2:0]        SEL  = 3'h2;
    localparam logic [DATA_W-1:0] ZERO = 48'h0000_0000_0000;
    localparam logic [DATA_W-1:0] ONE  = 48'h0000_0000_0001;
    logic              clk, rst_b, clkEn, outputEnN, sleepRequest, shutdown, burstMode;
    logic              clockQualifyN, addrAdvanceOrLoad, selectAN, selectB, selectCN, writeN;
    logic              dqOeN, readyOut, readyOeN;
    logic [LANES-1:0]  byteWriteLaneN;
    logic [TAW-1:0]    addr;
    logic [DATA_W-1:0] dqIn, dqOut;
    logic [DATA_W-1:0] refMem [2**TAW];
    int                fail_count = 0;
    int                compares   = 0;
    int                cycles     = 0;
    ftssp_top #(.AW(TAW), .DEPTH(16), .INIT_COUNT(4)) u_ftssp_top (
        .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .clockQualifyN(clockQualifyN),
        .addrAdvanceOrLoad(addrAdvanceOrLoad), .selectAN(selectAN), .selectB(selectB),
        .selectCN(selectCN), .writeN(writeN), .byteWriteLaneN(byteWriteLaneN), .addr(addr),
        .outputEnN(outputEnN), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
        .sleepRequest(sleepRequest), .shutdown(shutdown), .burstMode(burstMode),
        .readyOut(readyOut), .readyOeN(readyOeN));
    ftssp_ctl #(.AW(TAW)) u_ftssp_ctl (
        .clk(clk), .dqOut(dqOut), .dqOeN(dqOeN), .readyOut(readyOut), .readyOeN(readyOeN),
        .clockQualifyN(clockQualifyN), .addrAdvanceOrLoad(addrAdvanceOrLoad),
        .selectAN(selectAN), .selectB(selectB), .selectCN(selectCN), .writeN(writeN),
        .byteWriteLaneN(byteWriteLaneN), .addr(addr), .dqIn(dqIn));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            $display("[ERR] run length expected 4000 seen more");
            test_done();
        end
    end
    // ********
    // Helpers and scenarios
    // ********
    task automatic chk(input string nm, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic do_reset(input logic mode);
        @(posedge clk);
        rst_b     <= 1'h0;
        shutdown  <= 1'h0;
        burstMode <= mode;
        repeat (3) @(posedge clk);
        chk("readyOut reset", DATA_W'(readyOut), ZERO);
        chk("readyOeN reset", DATA_W'(readyOeN), ZERO);
        rst_b <= 1'h1;
        u_ftssp_ctl.waitReady();
        chk("readyOut up", DATA_W'(readyOut), ONE);
        chk("readyOeN first", DATA_W'(readyOeN), ZERO);
        @(posedge clk);
        #1;
        chk("readyOeN next", DATA_W'(readyOeN), ONE);
        $display("Test reset done");
    endtask : do_reset
    task automatic put(input logic [TAW-1:0] a, input logic [LANES-1:0] ln,
                       input logic [DATA_W-1:0] d);
        u_ftssp_ctl.wr(a, ln, d);
        for (int i = 0; i < LANES; i++) begin
            if (!ln[i]) begin
                refMem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
            end
        end
    endtask : put
    task automatic get(input logic [TAW-1:0] a, input string nm);
        u_ftssp_ctl.rd(SEL, a);
        #1;
        chk(nm, dqOut, refMem[a]);
        chk("dqOeN read", DATA_W'(dqOeN), ZERO);
    endtask : get
    task automatic fill();
        for (int i = 0; i < 4; i++) begin
            put(TAW'(8 + i), 6'h00, {8'(i), 40'h12_3456_789a});
        end
    endtask : fill
    task automatic t_rw();
        for (int i = 0; i < 4; i++) begin
            get(TAW'(8 + i), "read word");
        end
        put(8'h09, 6'h2a, 48'hffff_ffff_ffff);
        get(8'h09, "lane merge");
        $display("Test write read done");
    endtask : t_rw
    task automatic t_burst(input logic mode);
        logic [1:0] w;
        for (int b = 0; b < 4; b++) begin
            u_ftssp_ctl.cyc(1'h0, SEL, 1'h1, 6'h3f, TAW'(8 + b), 1'h0, 1'h0);
            for (int k = 0; k < 4; k++) begin
                u_ftssp_ctl.cyc(k < 3, k < 3 ? 3'h7 : 3'h4, 1'h1, 6'h3f, '0, 1'h0, 1'h0);
                w = mode ? 2'(b) ^ 2'(k) : 2'(b) + 2'(k);
                #1;
                chk("burst word", dqOut, refMem[8 + w]);
            end
        end
        $display("Test burst done");
    endtask : t_burst
    task automatic t_sel();
        for (int p = 0; p < 8; p++) begin
            u_ftssp_ctl.rd(3'(p), 8'h08);
            #1;
            chk("dqOeN select", DATA_W'(dqOeN), DATA_W'(p != 2));
        end
        $display("Test select done");
    endtask : t_sel
    task automatic t_oe();
        @(posedge clk);
        outputEnN <= 1'h1;
        repeat (3) u_ftssp_ctl.idle();
        u_ftssp_ctl.rd(SEL, 8'h08);
        #1;
        chk("dqOeN oe high", DATA_W'(dqOeN), ONE);
        @(posedge clk);
        outputEnN <= 1'h0;
        repeat (3) u_ftssp_ctl.idle();
        $display("Test output enable done");
    endtask : t_oe
    task automatic t_stretch();
        u_ftssp_ctl.cyc(1'h0, SEL, 1'h1, 6'h3f, 8'h0a, 1'h0, 1'h0);
        repeat (3) begin
            u_ftssp_ctl.cyc(1'h0, SEL, 1'h1, 6'h3f, 8'h0b, 1'h1, 1'h0);
            #1;
            chk("stretch data", dqOut, refMem[8'h0a]);
            chk("stretch drive", DATA_W'(dqOeN), ZERO);
        end
        u_ftssp_ctl.idle();
        $display("Test stretch done");
    endtask : t_stretch
    task automatic t_sleep();
        @(posedge clk);
        sleepRequest <= 1'h1;
        repeat (4) u_ftssp_ctl.idle();
        #1;
        chk("ready in sleep", DATA_W'(readyOut), ZERO);
        u_ftssp_ctl.rd(SEL, 8'h08);
        #1;
        chk("dqOeN in sleep", DATA_W'(dqOeN), ONE);
        @(posedge clk);
        sleepRequest <= 1'h0;
        u_ftssp_ctl.waitReady();
        get(8'h08, "after sleep");
        $display("Test sleep done");
    endtask : t_sleep
    task automatic t_shut();
        @(posedge clk);
        shutdown <= 1'h1;
        repeat (6) u_ftssp_ctl.idle();
        #1;
        chk("ready in shutdown", DATA_W'(readyOut), ZERO);
        u_ftssp_ctl.rd(SEL, 8'h08);
        #1;
        chk("dqOeN in shutdown", DATA_W'(dqOeN), ONE);
        $display("Test shutdown done");
        do_reset(1'h1);
    endtask : t_shut
    initial begin
        rst_b        = 1'h0;
        clkEn        = 1'h1;
        outputEnN    = 1'h0;
        sleepRequest = 1'h0;
        shutdown     = 1'h0;
        burstMode    = 1'h0;
        do_reset(1'h0);
        fill();
        t_rw();
        t_burst(1'h0);
        t_sel();
        t_oe();
        t_stretch();
        t_sleep();
        t_shut();
        fill();
        t_burst(1'h1);
        test_done();
    end
endmodule : tb_top
